// file: sas_pkg.sv
/*
 * Shared constants and types for the setpoint action sequencer.
 * Assumes one clock domain and a step table held by the user logic.
 */
`default_nettype none

package sas_pkg;

	// ==========================================================
	// Widths
	localparam int IDX_W   = 5;
	localparam int NUM_W   = 6;
	localparam int W_W     = 32;
	localparam int CNT_W   = 16;
	localparam int STEPS   = 32;

	// ==========================================================
	// Target kinds
	localparam logic [2:0] TGT_ABS   = 3'h0;
	localparam logic [2:0] TGT_ADD   = 3'h1;
	localparam logic [2:0] TGT_SUB   = 3'h2;
	localparam logic [2:0] TGT_PCT_T = 3'h3;
	localparam logic [2:0] TGT_PCT_C = 3'h4;

	// ==========================================================
	// Option encodings
	localparam logic [1:0] OPT_OFF   = 2'h0;
	localparam logic [1:0] OPT_ON    = 2'h1;
	localparam logic [1:0] OPT_QUIET = 2'h2;
	localparam logic [1:0] OPT_WAIT  = 2'h2;

	// ==========================================================
	// Action stages, in execution order
	localparam logic [2:0] STG_ZACC  = 3'h0;
	localparam logic [2:0] STG_ZTARE = 3'h1;
	localparam logic [2:0] STG_ACC   = 3'h2;
	localparam logic [2:0] STG_PRINT = 3'h3;
	localparam logic [2:0] STG_CTARE = 3'h4;

	// ==========================================================
	// Arithmetic and reset values
	localparam logic signed [63:0] PCT_DIV    = 64'sh0000_0064;
	localparam logic [CNT_W-1:0]   MISS_RST   = 16'h0000;
	localparam logic [CNT_W-1:0]   MISS_MAX   = 16'hFFFF;
	localparam logic [IDX_W-1:0]   IDX_RST    = 5'h00;
	localparam logic [STEPS-1:0]   VEC_RST    = 32'h0000_0000;
	localparam logic [W_W-1:0]     WORD_RST   = 32'h0000_0000;

	// ==========================================================
	// Sequencer states, Gray along idle-run-act-pause
	typedef enum logic [1:0] {
		SAS_IDLE  = 2'h0,
		SAS_RUN   = 2'h1,
		SAS_ACT   = 2'h3,
		SAS_PAUSE = 2'h2
	} sas_state_t;

endpackage

`default_nettype wire

// file: sas_target_calc.sv
/*
 * Target weight for one setpoint from its kind and its reference.
 * Assumes the reference target and capture are already selected.
 */
`default_nettype none

module sas_target_calc
	import sas_pkg::*;
(
	// Step description
	input  wire logic              [2:0]     i_kind,
	input  wire logic signed       [W_W-1:0] i_value,
	// Referenced step
	input  wire logic signed       [W_W-1:0] i_ref_target,
	input  wire logic signed       [W_W-1:0] i_ref_capture,
	// Result
	output logic signed            [W_W-1:0] o_target
);

	// ==========================================================
	// Percentage of a base, wide product so nothing overflows early
	function automatic logic signed [W_W-1:0] pct(
		input logic signed [W_W-1:0] p,
		input logic signed [W_W-1:0] b
	);
		logic signed [63:0] prod;
		logic signed [63:0] quot;
		prod = 64'(p) * 64'(b);
		quot = prod / PCT_DIV;
		return quot[W_W-1:0];
	endfunction

	// ==========================================================
	// Kind select
	always_comb
	begin
		case (i_kind)
			TGT_ADD:   o_target = i_ref_target + i_value;
			TGT_SUB:   o_target = i_ref_target - i_value;
			TGT_PCT_T: o_target = pct(i_value, i_ref_target);
			TGT_PCT_C: o_target = pct(i_value, i_ref_capture);
			default:   o_target = i_value;
		endcase
	end

endmodule // sas_target_calc

`default_nettype wire

// file: sas_sequencer.sv
/*
 * Batch setpoint sequencer: step walk, trip test, tolerance misses,
 * relative targets, ordered on-hit actions and alarm.
 * Assumes the step table is a same-clock lookup indexed by o_step_idx.
 */
// Functional notes
// - Trip step outside tolerance window: no learn pulse, miss counted.
// - Misses reaching miss_limit pause the batch and set the error.
// - A miss_limit of zero never pauses.
// - Error stays until batch restart or reset clears it.
// - Added offset target is reference value plus own value.
// - Subtracted offset target is reference value minus own value.
// - Percent of target uses the referenced step's target.
// - Percent of captured uses the referenced step's captured weight.
// - Batch bit selects sequence step, else continuous evaluation.
// - Zero accumulator on hit when enabled.
// - Zero tare on hit when enabled.
// - Accumulate off, on with print, or silent.
// - Print off, on, or after standstill.
// - Capture tare on hit, regardless of legal for trade mode.
// - Actions run: zero acc, zero tare, accumulate, print, capture tare.
// - Alarm while batch step active or continuous step not tripped.
// - Parallel step begins when its start step, not itself, began.
// - Higher step output active below target, lower step at or above.
`default_nettype none

module sas_sequencer
	import sas_pkg::*;
(
	// Clock and reset
	input  wire logic                     i_ref_clk,
	input  wire logic                     i_rst,
	// Batch commands
	input  wire logic                     i_batch_start,
	input  wire logic                     i_batch_reset,
	// Scale
	input  wire logic signed [W_W-1:0]    i_weight,
	input  wire logic                     i_standstill,
	// Step table lookup
	output logic             [IDX_W-1:0]  o_step_idx,
	input  wire logic        [IDX_W-1:0]  i_last_step,
	input  wire logic signed [W_W-1:0]    i_sp_value,
	input  wire logic        [2:0]        i_sp_kind,
	input  wire logic        [NUM_W-1:0]  i_sp_ref,
	input  wire logic        [NUM_W-1:0]  i_sp_start_ref,
	input  wire logic                     i_sp_batch,
	input  wire logic                     i_sp_trip_lower,
	input  wire logic                     i_sp_parallel,
	input  wire logic        [W_W-1:0]    i_sp_tol_window,
	input  wire logic        [CNT_W-1:0]  i_sp_miss_limit,
	input  wire logic                     i_sp_zero_acc,
	input  wire logic                     i_sp_zero_tare,
	input  wire logic        [1:0]        i_sp_accum,
	input  wire logic        [1:0]        i_sp_print,
	input  wire logic                     i_sp_cap_tare,
	input  wire logic                     i_sp_alarm_en,
	// Status
	output logic                          o_running,
	output logic                          o_paused,
	output logic                          o_tol_error,
	output logic                          o_step_output,
	output logic                          o_alarm,
	output logic signed      [W_W-1:0]    o_target,
	output logic             [STEPS-1:0]  o_par_active,
	// Action pulses
	output logic                          o_learn_update,
	output logic                          o_acc_clear,
	output logic                          o_tare_clear,
	output logic                          o_acc_add,
	output logic                          o_print_req,
	output logic                          o_tare_capture
);

	// ==========================================================
	// Step number 1..32 to table index
	function automatic logic [IDX_W-1:0] num_to_idx(input logic [NUM_W-1:0] n);
		logic [NUM_W-1:0] t;
		t = n - 6'h01;
		return t[IDX_W-1:0];
	endfunction

	sas_state_t              state_r, state_nxt;
	logic [IDX_W-1:0]        idx_r, idx_nxt;
	logic                    first_r, first_nxt;
	logic [2:0]              stage_r, stage_nxt;
	logic [CNT_W-1:0]        miss_r, miss_nxt, miss_inc;
	logic                    err_r, err_nxt, err_set, err_clr;
	logic                    pend_r, pend_nxt;
	logic [STEPS-1:0]        began_r, began_nxt, par_r, par_nxt, cont_r, cont_nxt;
	logic signed [W_W-1:0]   tgt_mem [STEPS];
	logic signed [W_W-1:0]   cap_mem [STEPS];
	logic signed [W_W-1:0]   tgt_live, tgt_r;
	logic                    tgt_we, cap_we, adv, tripped, in_tol, tol_eval;
	logic signed [W_W:0]     diff, mag;
	logic [IDX_W-1:0]        ref_i, start_i;
	logic                    out_nxt, alarm_nxt, learn_nxt;
	logic                    zacc_nxt, ztare_nxt, add_nxt, prn_nxt, ctare_nxt;
	logic                    out_r, alarm_r, learn_r;
	logic                    zacc_r, ztare_r, add_r, prn_r, ctare_r;

	assign ref_i   = num_to_idx(i_sp_ref);
	assign start_i = num_to_idx(i_sp_start_ref);

	// ==========================================================
	// Relative target from stored targets and captures
	sas_target_calc u_calc (
		.i_kind        (i_sp_kind),
		.i_value       (i_sp_value),
		.i_ref_target  (tgt_mem[ref_i]),
		.i_ref_capture (cap_mem[ref_i]),
		.o_target      (tgt_live)
	);

	// ==========================================================
	// Trip and tolerance tests on the live weight
	always_comb
	begin
		tripped = i_sp_trip_lower ? (i_weight < tgt_live) : (i_weight >= tgt_live);
		diff    = {i_weight[W_W-1], i_weight} - {tgt_live[W_W-1], tgt_live};
		mag     = diff[W_W] ? -diff : diff;
		in_tol  = mag <= $signed({1'b0, i_sp_tol_window});
		// Saturate so a long run of misses cannot wrap back to zero
		miss_inc = (miss_r == MISS_MAX) ? miss_r : miss_r + 16'h0001;
	end

	// ==========================================================
	// Sequencer next state
	always_comb
	begin
		state_nxt = state_r;
		idx_nxt   = idx_r;
		first_nxt = 1'b0;
		stage_nxt = stage_r;
		miss_nxt  = miss_r;
		pend_nxt  = pend_r;
		began_nxt = began_r;
		par_nxt   = par_r;
		cont_nxt  = cont_r;
		tgt_we    = 1'b0;
		cap_we    = 1'b0;
		adv       = 1'b0;
		tol_eval  = 1'b0;
		err_set   = 1'b0;
		err_clr   = 1'b0;
		learn_nxt = 1'b0;
		zacc_nxt  = 1'b0;
		ztare_nxt = 1'b0;
		add_nxt   = 1'b0;
		prn_nxt   = 1'b0;
		ctare_nxt = 1'b0;
		case (state_r)
			SAS_IDLE:
			begin
				if (i_batch_start)
				begin
					state_nxt = SAS_RUN;
					idx_nxt   = IDX_RST;
					first_nxt = 1'b1;
					miss_nxt  = MISS_RST;
					began_nxt = VEC_RST;
					par_nxt   = VEC_RST;
					cont_nxt  = VEC_RST;
					err_clr   = 1'b1;
				end
			end
			SAS_RUN:
			begin
				if (first_r)
				begin
					began_nxt[idx_r] = 1'b1;
					tgt_we           = 1'b1;
				end
				if (i_sp_parallel)
				begin
					// Started by another step only, never by itself
					if (i_sp_start_ref != 6'h00 && i_sp_start_ref <= 6'h20 &&
						start_i != idx_r && began_r[start_i])
						par_nxt[idx_r] = 1'b1;
					adv = 1'b1;
				end
				else if (!i_sp_batch)
				begin
					// Continuous: act on the rising edge of the trip only
					cont_nxt[idx_r] = tripped;
					if (tripped && !cont_r[idx_r])
					begin
						state_nxt = SAS_ACT;
						stage_nxt = STG_ZACC;
						cap_we    = 1'b1;
					end
					else
						adv = 1'b1;
				end
				else if (tripped)
				begin
					state_nxt = SAS_ACT;
					stage_nxt = STG_ZACC;
					cap_we    = 1'b1;
					tol_eval  = 1'b1;
					if (in_tol)
					begin
						miss_nxt  = MISS_RST;
						learn_nxt = 1'b1;
					end
					else
					begin
						miss_nxt = miss_inc;
						if (i_sp_miss_limit != MISS_RST && miss_inc >= i_sp_miss_limit)
						begin
							pend_nxt = 1'b1;
							err_set  = 1'b1;
						end
					end
				end
			end
			SAS_ACT:
			begin
				stage_nxt = stage_r + 3'h1;
				case (stage_r)
					STG_ZACC:  zacc_nxt  = i_sp_zero_acc;
					STG_ZTARE: ztare_nxt = i_sp_zero_tare;
					STG_ACC:   add_nxt   = i_sp_accum != OPT_OFF;
					STG_PRINT:
					begin
						// Standstill wait holds the whole sequence here
						if (i_sp_print == OPT_WAIT && !i_standstill)
							stage_nxt = stage_r;
						else
							prn_nxt = i_sp_print != OPT_OFF || i_sp_accum == OPT_ON;
					end
					STG_CTARE:
					begin
						ctare_nxt = i_sp_cap_tare;
						if (pend_r)
						begin
							state_nxt = SAS_PAUSE;
							pend_nxt  = 1'b0;
						end
						else
						begin
							state_nxt = SAS_RUN;
							adv       = 1'b1;
						end
					end
					default: state_nxt = SAS_IDLE;
				endcase
			end
			SAS_PAUSE:
			begin
				if (i_batch_start)
				begin
					state_nxt = SAS_RUN;
					adv       = 1'b1;
					miss_nxt  = MISS_RST;
					err_clr   = 1'b1;
				end
			end
			default: state_nxt = SAS_IDLE;
		endcase
		if (adv)
		begin
			if (idx_r == i_last_step)
				state_nxt = SAS_IDLE;
			else
			begin
				idx_nxt   = idx_r + 5'h01;
				first_nxt = 1'b1;
			end
		end
		// Reset of the batch overrides the walk
		if (i_batch_reset)
		begin
			state_nxt = SAS_IDLE;
			idx_nxt   = IDX_RST;
			first_nxt = 1'b0;
			miss_nxt  = MISS_RST;
			pend_nxt  = 1'b0;
			err_clr   = 1'b1;
		end
		// A new error wins over a clear in the same cycle
		err_nxt   = err_set | (err_r & ~err_clr);
		out_nxt   = state_r == SAS_RUN && i_sp_batch && !i_sp_parallel && !tripped;
		alarm_nxt = i_sp_alarm_en && state_r == SAS_RUN && !tripped;
	end

	// ==========================================================
	// Registers
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_r <= SAS_IDLE;
			idx_r   <= IDX_RST;
			first_r <= 1'b0;
			stage_r <= STG_ZACC;
			miss_r  <= MISS_RST;
			err_r   <= 1'b0;
			pend_r  <= 1'b0;
			began_r <= VEC_RST;
			par_r   <= VEC_RST;
			cont_r  <= VEC_RST;
			tgt_r   <= WORD_RST;
			out_r   <= 1'b0;
			alarm_r <= 1'b0;
			learn_r <= 1'b0;
			zacc_r  <= 1'b0;
			ztare_r <= 1'b0;
			add_r   <= 1'b0;
			prn_r   <= 1'b0;
			ctare_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			idx_r   <= idx_nxt;
			first_r <= first_nxt;
			stage_r <= stage_nxt;
			miss_r  <= miss_nxt;
			err_r   <= err_nxt;
			pend_r  <= pend_nxt;
			began_r <= began_nxt;
			par_r   <= par_nxt;
			cont_r  <= cont_nxt;
			tgt_r   <= tgt_live;
			out_r   <= out_nxt;
			alarm_r <= alarm_nxt;
			learn_r <= learn_nxt;
			zacc_r  <= zacc_nxt;
			ztare_r <= ztare_nxt;
			add_r   <= add_nxt;
			prn_r   <= prn_nxt;
			ctare_r <= ctare_nxt;
		end
	end

	// Step memories have no reset; reads before a write are don't-care
	always_ff @(posedge i_ref_clk)
	begin
		if (tgt_we)
			tgt_mem[idx_r] <= tgt_live;
		if (cap_we)
			cap_mem[idx_r] <= i_weight;
	end

	assign o_step_idx     = idx_r;
	assign o_running      = state_r == SAS_RUN || state_r == SAS_ACT;
	assign o_paused       = state_r == SAS_PAUSE;
	assign o_tol_error    = err_r;
	assign o_step_output  = out_r;
	assign o_alarm        = alarm_r;
	assign o_target       = tgt_r;
	assign o_par_active   = par_r;
	assign o_learn_update = learn_r;
	assign o_acc_clear    = zacc_r;
	assign o_tare_clear   = ztare_r;
	assign o_acc_add      = add_r;
	assign o_print_req    = prn_r;
	assign o_tare_capture = ctare_r;

	// ==========================================================
	// Checks
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	chk_miss_no_learn: assert property (tol_eval && !in_tol |=> !o_learn_update)
		else $error("learn pulse after out of tolerance hit");
	chk_limit_pause: assert property (tol_eval && !in_tol && i_sp_miss_limit != 16'h0000 &&
		miss_inc >= i_sp_miss_limit |=> o_tol_error ##[1:300] o_paused)
		else $error("miss limit reached without pause");
	chk_zero_no_pause: assert property (tol_eval && i_sp_miss_limit == 16'h0000 && !pend_r
		|=> !pend_r)
		else $error("pause armed with zero miss limit");
	chk_err_sticky: assert property (o_tol_error && !i_batch_start && !i_batch_reset
		|=> o_tol_error)
		else $error("tolerance error dropped on its own");
	chk_add_target: assert property (i_sp_kind == TGT_ADD
		|=> o_target == $past(tgt_mem[ref_i]) + $past(i_sp_value))
		else $error("added offset target wrong");
	chk_sub_target: assert property (i_sp_kind == TGT_SUB
		|=> o_target == $past(tgt_mem[ref_i]) - $past(i_sp_value))
		else $error("subtracted offset target wrong");
	chk_action_order: assert property (o_acc_add |=> (!o_acc_clear && !o_tare_clear)[*3])
		else $error("earlier action after accumulate");
	chk_wait_hold: assert property (state_r == SAS_ACT && stage_r == STG_PRINT &&
		i_sp_print == OPT_WAIT && !i_standstill |=> !o_print_req)
		else $error("print before standstill");
	chk_zero_acc: assert property (state_r == SAS_ACT && stage_r == STG_ZACC && i_sp_zero_acc
		|=> o_acc_clear)
		else $error("accumulator not zeroed on hit");
	chk_high_output: assert property (o_step_output && !$past(i_sp_trip_lower)
		|-> $past(i_weight) < $past(tgt_live))
		else $error("higher step output at or above target");

endmodule // sas_sequencer

`default_nettype wire

// file: tb_top.sv
/*
 * Self-checking bench for the setpoint action sequencer.
 * Assumes sas_pkg and sas_sequencer are compiled first; the bench
 * holds the step table and answers the lookup in the same cycle.
 */
`default_nettype none

module tb_top
	import sas_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================================
	// Step table and weights
	typedef struct packed {
		logic signed [W_W-1:0]   value;
		logic        [2:0]       kind;
		logic        [NUM_W-1:0] refn;
		logic                    batch;
		logic                    lower;
		logic        [W_W-1:0]   tolw;
		logic        [CNT_W-1:0] lim;
		logic                    zacc;
		logic                    ztare;
		logic        [1:0]       accum;
		logic        [1:0]       print;
		logic                    ctare;
		logic                    alarm_en;
		logic                    par;
		logic        [NUM_W-1:0] sref;
	} sas_tb_step_t;

	localparam logic signed [W_W-1:0] W_T    = 32'sh0000_03E8;
	localparam logic signed [W_W-1:0] W_HI   = 32'sh0000_041A;
	localparam logic signed [W_W-1:0] W_NEAR = 32'sh0000_0415;
	localparam logic        [W_W-1:0] W_WIN  = 32'h0000_000A;

	logic                    clk;
	logic                    rst;
	logic                    start;
	logic                    breset;
	logic                    still;
	logic signed [W_W-1:0]   weight;
	logic        [IDX_W-1:0] idx;
	logic        [IDX_W-1:0] last;
	logic                    running;
	logic                    paused;
	logic                    tol_err;
	logic                    step_out;
	logic                    alarm;
	logic signed [W_W-1:0]   target;
	logic        [STEPS-1:0] par_act;
	logic        [5:0]       pv;
	sas_tb_step_t            tbl [STEPS];
	sas_tb_step_t            cur;
	int                      failures;
	int                      comparisons;
	int                      seed;
	int                      seen_q [$];

	// Same-cycle table lookup, as the user logic would do it
	assign cur = tbl[idx];

	sas_sequencer i_dut (
		.i_ref_clk(clk), .i_rst(rst),
		.i_batch_start(start), .i_batch_reset(breset),
		.i_weight(weight), .i_standstill(still),
		.o_step_idx(idx), .i_last_step(last),
		.i_sp_value(cur.value), .i_sp_kind(cur.kind),
		.i_sp_ref(cur.refn), .i_sp_start_ref(cur.sref),
		.i_sp_batch(cur.batch), .i_sp_trip_lower(cur.lower),
		.i_sp_parallel(cur.par), .i_sp_tol_window(cur.tolw),
		.i_sp_miss_limit(cur.lim), .i_sp_zero_acc(cur.zacc),
		.i_sp_zero_tare(cur.ztare), .i_sp_accum(cur.accum),
		.i_sp_print(cur.print), .i_sp_cap_tare(cur.ctare),
		.i_sp_alarm_en(cur.alarm_en),
		.o_running(running), .o_paused(paused), .o_tol_error(tol_err),
		.o_step_output(step_out), .o_alarm(alarm), .o_target(target),
		.o_par_active(par_act),
		.o_learn_update(pv[5]), .o_acc_clear(pv[0]), .o_tare_clear(pv[1]),
		.o_acc_add(pv[2]), .o_print_req(pv[3]), .o_tare_capture(pv[4])
	);

	// ==========================================================
	// Clock, and a log of pulse codes taken mid-cycle, once they have settled
	always #12.5 clk = ~clk;

	always @(negedge clk)
	begin
		for (int k = 0; k < 6; k++)
			if (pv[k])
				seen_q.push_back(k);
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out;
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// One-cycle batch command: reset when rs, else start
	task automatic cmd(input bit rs);
		@(negedge clk);
		breset = rs;
		start = !rs;
		@(negedge clk);
		breset = 1'b0;
		start = 1'b0;
	endtask

	// Plain absolute higher batch steps, always in tolerance
	task automatic fresh;
		cmd(1'b1);
		foreach (tbl[i])
		begin
			tbl[i] = '0;
			tbl[i].batch = 1'b1;
			tbl[i].value = W_T;
			tbl[i].tolw = 32'hFFFF_FFFF;
		end
		// Let pulses of the reset edge drain before the log is cleared
		cyc(1);
		seen_q.delete();
	endtask

	function automatic int count(input int code);
		int n;
		n = 0;
		foreach (seen_q[i])
			if (seen_q[i] == code)
				n++;
		return n;
	endfunction

	// Step of the pause in a three-step run (3 when none), and learn pulses
	function automatic int exp_pause(input int lim, input int v1, output int lrn);
		int cnt;
		int v;
		cnt = 0;
		lrn = 0;
		for (int s = 0; s < 3; s++)
		begin
			v = (s == 1) ? v1 : int'(W_T);
			if (int'(W_HI) - v > int'(W_WIN) || v - int'(W_HI) > int'(W_WIN))
				cnt++;
			else
			begin
				cnt = 0;
				lrn++;
			end
			if (lim != 0 && cnt >= lim)
				return s;
		end
		return 3;
	endfunction

	function automatic logic signed [W_W-1:0] exp_target(input logic [2:0] k,
		input logic signed [W_W-1:0] a, input logic signed [W_W-1:0] b,
		input logic signed [W_W-1:0] cap);
		logic signed [63:0] base;
		base = (k == TGT_PCT_C) ? 64'(cap) : 64'(a);
		case (k)
			TGT_ADD: return a + b;
			TGT_SUB: return a - b;
			default: return W_W'((base * b) / 64'sh0000_0000_0000_0064);
		endcase
	endfunction

	// ==========================================================
	// Scenarios
	task automatic t_order;
		int exp_q [$];
		fresh();
		last = 5'h00;
		weight = 32'sh0000_0000;
		tbl[0].zacc = 1'b1;
		tbl[0].ztare = 1'b1;
		tbl[0].accum = OPT_ON;
		tbl[0].print = OPT_ON;
		tbl[0].ctare = 1'b1;
		tbl[0].alarm_en = 1'b1;
		cmd(1'b0);
		cyc(2);
		check(running, 1'b1);
		check(step_out, 1'b1);
		check(alarm, 1'b1);
		weight = W_T;
		cyc(12);
		exp_q = '{5, 0, 1, 2, 3, 4};
		check(seen_q.size(), 6);
		foreach (seen_q[i])
			check(seen_q[i], exp_q[i]);
		check(running, 1'b0);
		$display("test order done");
	endtask

	task automatic t_wait;
		fresh();
		weight = 32'sh0000_0000;
		still = 1'b0;
		tbl[0].accum = OPT_QUIET;
		tbl[0].print = OPT_WAIT;
		cmd(1'b0);
		weight = W_T;
		cyc(12);
		check(count(2), 1);
		check(count(3), 0);
		still = 1'b1;
		cyc(6);
		check(count(3), 1);
		$display("test wait done");
	endtask

	task automatic t_tol;
		int ps;
		int lrn;
		int n;
		logic [CNT_W-1:0]      lims [4];
		logic signed [W_W-1:0] v1s [4];
		lims = '{16'h0000, 16'h0001, 16'h0002, 16'h0002};
		v1s = '{W_T, W_NEAR, W_NEAR, W_T};
		for (int c = 0; c < 4; c++)
		begin
			fresh();
			last = 5'h02;
			weight = W_HI;
			for (int s = 0; s < 3; s++)
			begin
				tbl[s].tolw = W_WIN;
				tbl[s].lim = lims[c];
			end
			tbl[1].value = v1s[c];
			ps = exp_pause(int'(lims[c]), int'(v1s[c]), lrn);
			cmd(1'b0);
			n = 0;
			while (running === 1'b1 && n < 80)
			begin
				cyc(1);
				n++;
			end
			check(n < 80, 1'b1);
			cyc(2);
			check(paused, ps != 3);
			check(tol_err, ps != 3);
			check(count(5), lrn);
			if (ps != 3)
			begin
				// Restart on one case, batch reset on the other
				cmd(c == 3);
				check(tol_err, 1'b0);
			end
		end
		$display("test tolerance done");
	endtask

	task automatic t_rel;
		int n;
		logic signed [W_W-1:0] a;
		logic signed [W_W-1:0] b;
		logic signed [W_W-1:0] cap;
		for (int k = 1; k <= 4; k++)
		begin
			fresh();
			a = 32'sh0000_1388 + ($random(seed) & 32'sh0000_7FFF);
			b = 32'sh0000_0065 + ($random(seed) & 32'sh0000_003F);
			cap = a + 32'sh0000_0001 + ($random(seed) & 32'sh0000_001F);
			tbl[0].value = a;
			tbl[1].value = b;
			tbl[1].kind = k[2:0];
			tbl[1].refn = 6'h01;
			tbl[1].lower = (k[2:0] == TGT_SUB);
			last = 5'h01;
			weight = cap;
			cmd(1'b0);
			n = 0;
			while (idx !== 5'h01 && n < 40)
			begin
				cyc(1);
				n++;
			end
			cyc(3);
			check(n < 40, 1'b1);
			check(target, exp_target(k[2:0], a, b, cap));
			check(step_out, 1'b1);
		end
		$display("test relative done");
	endtask

	task automatic t_cont;
		fresh();
		tbl[0].batch = 1'b0;
		tbl[0].accum = OPT_ON;
		last = 5'h00;
		weight = 32'sh0000_01F4;
		tbl[0].alarm_en = 1'b1;
		cmd(1'b0);
		// Alarm shows for the one cycle the untripped step is walked
		cyc(1);
		check(alarm, 1'b1);
		cyc(5);
		check(running, 1'b0);
		check(count(2), 0);
		weight = 32'sh0000_05DC;
		cmd(1'b0);
		cyc(12);
		check(count(2), 1);
		check(count(3), 1);
		$display("test continuous done");
	endtask

	// Parallel steps: one started by an earlier step, one naming itself
	task automatic t_par;
		int n;
		fresh();
		last = 5'h02;
		weight = W_T;
		tbl[0].accum = OPT_QUIET;
		tbl[1].par = 1'b1;
		tbl[1].sref = 6'h01;
		tbl[2].par = 1'b1;
		tbl[2].sref = 6'h03;
		cmd(1'b0);
		n = 0;
		while (running === 1'b1 && n < 40)
		begin
			cyc(1);
			n++;
		end
		check(n < 40, 1'b1);
		check(par_act, 32'h0000_0002);
		check(count(2), 1);
		check(count(3), 0);
		$display("test parallel done");
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		start = 1'b0;
		breset = 1'b0;
		still = 1'b1;
		weight = 32'sh0000_0000;
		last = 5'h00;
		seed = 4687;
		failures = 0;
		comparisons = 0;
		foreach (tbl[i])
			tbl[i] = '0;
		cyc(4);
		check(tol_err, 1'b0);
		cyc(4);
		rst = 1'b0;
		cyc(2);
		t_order();
		t_wait();
		t_tol();
		t_rel();
		t_cont();
		t_par();
		close_out();
	end

	// Watchdog: the tests need well under 2000 cycles
	initial
	begin
		#(25 * 20000);
		failures++;
		close_out();
	end

endmodule // tb_top

`default_nettype wire
